// *** eba_cpu_model.sv ***
`timescale 1ns/1ns
module eba_cpu_model (
    input  wire       ref_clk_i,
    input  wire       stall_i,
    input  wire [7:0] rdata_i,
    output reg  [5:0] addr_o,
    output reg        wr_o,
    output reg        rd_o,
    output reg  [7:0] wdata_o
);
    integer n;
    initial begin
        {addr_o, wr_o, rd_o, wdata_o} = 16'h0000;
    end
    task acc(input [5:0] a, input [7:0] d, input w, output [7:0] q);
        begin
            @(negedge ref_clk_i);
            for (n = 0; n < 8 && stall_i; n = n + 1) @(negedge ref_clk_i);
            if (stall_i) begin
                eba_port_bench.fails = eba_port_bench.fails + 1;
                eba_port_bench.end_sim;
            end
            {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
            @(negedge ref_clk_i);
            {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'h0};
            @(negedge ref_clk_i);
            q = rdata_i;
        end
    endtask
endmodule

// *** eba_defines.vh ***
`ifndef EBA_DEFINES_VH
`define EBA_DEFINES_VH

// I/O register addresses (arbitrary placement in a 6-bit I/O space)
`define EBA_IO_AW           6
`define EBA_ADDR_CONTROL    6'h1F
`define EBA_ADDR_VALUE      6'h20
`define EBA_ADDR_PTR_LOW    6'h21
`define EBA_ADDR_PTR_HIGH   6'h22

// Control register fields
`define EBA_BIT_READ        0
`define EBA_BIT_WRITE       1
`define EBA_BIT_ARM         2
`define EBA_BIT_IRQ_EN      3
`define EBA_BIT_MODE_LO     4
`define EBA_BIT_MODE_HI     5

// Programming modes
`define EBA_MODE_ATOMIC     2'h0
`define EBA_MODE_ERASE      2'h1
`define EBA_MODE_PROG       2'h2
`define EBA_MODE_RSVD       2'h3

// Erased cell value
`define EBA_ERASED_BYTE     8'hFF

// Timing in clock cycles
`define EBA_ARM_CYCLES      3'h4
`define EBA_READ_STALL      3'h4
`define EBA_WRITE_STALL     3'h2

// Programming times in microseconds and clock frequency in MHz
`define EBA_T_ATOMIC_US     3400
`define EBA_T_SPLIT_US      1800
`define EBA_CLK_MHZ         250

`endif

// *** eba_port.v ***
`timescale 1ns/1ns
// Notes on behaviour
// - A separate byte-wide store of 256 or 512 bytes is provided with per-byte read and write.
// - Pointer, value and control registers are reached over the I/O register space.
// - Writes are self-timed and a busy bit shows when the next byte may be written.
// - A write starts only after the dedicated arming sequence, never from one stray write.
// - A triggered read stalls the processor for four clock cycles.
// - A triggered write stalls the processor for two clock cycles.
// - The pointer sits in bits 8..0 of a 16-bit pair and bits 15..9 read as zero.
// - Bytes are addressed linearly from zero up to the top of the store by the pointer.
// - A write programs the held value byte into the location the pointer selects.
// - After a read the value register holds the byte fetched from the pointed location.
// - A two-bit mode field selects erase-and-program, erase only, program only or reserved.
// - The arm bit clears itself after four cycles and the strobe only starts a write inside it.
// - The write strobe clears when the write time has elapsed, serving as a busy flag.
// - While a write runs, read strobes and pointer changes are ignored.
`include "eba_defines.vh"

module eba_port #(
    parameter DEPTH       = 512,
    parameter AW          = 9,
    parameter T_ATOMIC_CY = `EBA_T_ATOMIC_US * `EBA_CLK_MHZ,
    parameter T_SPLIT_CY  = `EBA_T_SPLIT_US * `EBA_CLK_MHZ
) (
    input  wire                   ref_clk_i,
    input  wire                   rst_i,
    input  wire [`EBA_IO_AW-1:0]  io_addr_i,
    input  wire                   io_wr_i,
    input  wire                   io_rd_i,
    input  wire [7:0]             io_wdata_i,
    output reg  [7:0]             io_rdata_o,
    output reg                    cpu_stall_o,
    output reg                    nv_ready_o,
    output reg                    nv_ready_irq_o
);

    reg  [7:0]    mem_r [0:DEPTH-1];
    reg  [AW-1:0] nv_byte_pointer_r;
    reg  [7:0]    nv_byte_value_r;
    reg  [1:0]    nv_prog_mode_r;
    reg           nv_ready_irq_enable_r;
    reg           nv_write_arm_r;
    reg           nv_write_strobe_r;
    reg           nv_read_strobe_r;
    reg  [2:0]    arm_cnt_r;
    reg  [2:0]    stall_cnt_r;
    reg  [31:0]   prog_cnt_r;
    reg  [1:0]    op_mode_r;
    reg  [AW-1:0] op_addr_r;
    reg  [7:0]    op_data_r;

    wire [15:0] ptr_full;
    wire        wr_ctl;
    wire        start_write;
    wire        start_read;
    wire [7:0]  ctl_rd;
    wire [7:0]  prog_byte;

    assign ptr_full = {{(16-AW){1'b0}}, nv_byte_pointer_r};
    assign wr_ctl   = io_wr_i && (io_addr_i == `EBA_ADDR_CONTROL);
    assign start_write = wr_ctl && io_wdata_i[`EBA_BIT_WRITE] && nv_write_arm_r
                         && !nv_write_strobe_r;
    assign start_read  = wr_ctl && io_wdata_i[`EBA_BIT_READ]
                         && !nv_write_strobe_r;
    assign ctl_rd = {2'h0, nv_prog_mode_r, nv_ready_irq_enable_r, nv_write_arm_r,
                     nv_write_strobe_r, nv_read_strobe_r};
    // Erase only leaves erased byte; program only can clear bits
    assign prog_byte = (op_mode_r == `EBA_MODE_ERASE) ? `EBA_ERASED_BYTE :
                       (op_mode_r == `EBA_MODE_PROG) ? (mem_r[op_addr_r] & op_data_r) :
                       op_data_r;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            io_rdata_o            <= 8'h00;
            cpu_stall_o           <= 1'b0;
            nv_ready_o            <= 1'b0;
            nv_ready_irq_o        <= 1'b0;
            nv_byte_value_r       <= 8'h00;
            nv_byte_pointer_r     <= {AW{1'b0}};
            nv_ready_irq_enable_r <= 1'b0;
            nv_write_arm_r        <= 1'b0;
            nv_read_strobe_r      <= 1'b0;
            arm_cnt_r             <= 3'h0;
            stall_cnt_r           <= 3'h0;
            op_mode_r             <= `EBA_MODE_ATOMIC;
            op_addr_r             <= {AW{1'b0}};
            op_data_r             <= 8'h00;
            // Strobe and timer of a write in flight run on through reset; op_mode_r, op_addr_r and op_data_r are cleared by it
            if (!nv_write_strobe_r)
                nv_prog_mode_r <= `EBA_MODE_ATOMIC;
            if (nv_write_strobe_r && prog_cnt_r > 32'h1) begin
                prog_cnt_r <= prog_cnt_r - 32'h1;
            end else begin
                if (nv_write_strobe_r && op_mode_r != `EBA_MODE_RSVD)
                    mem_r[op_addr_r] <= prog_byte;
                nv_write_strobe_r <= 1'b0;
                prog_cnt_r        <= 32'h0;
            end
        end else begin
            nv_ready_o     <= !nv_write_strobe_r;
            nv_ready_irq_o <= !nv_write_strobe_r && nv_ready_irq_enable_r;
            nv_read_strobe_r <= 1'b0;

            if (io_rd_i) begin
                if (io_addr_i == `EBA_ADDR_CONTROL)
                    io_rdata_o <= ctl_rd;
                else if (io_addr_i == `EBA_ADDR_VALUE)
                    io_rdata_o <= nv_byte_value_r;
                else if (io_addr_i == `EBA_ADDR_PTR_LOW)
                    io_rdata_o <= ptr_full[7:0];
                else if (io_addr_i == `EBA_ADDR_PTR_HIGH)
                    io_rdata_o <= ptr_full[15:8];
                else
                    io_rdata_o <= 8'h00;
            end

            if (io_wr_i && io_addr_i == `EBA_ADDR_VALUE)
                nv_byte_value_r <= io_wdata_i;
            if (io_wr_i && !nv_write_strobe_r) begin
                if (io_addr_i == `EBA_ADDR_PTR_LOW)
                    nv_byte_pointer_r[7:0] <= io_wdata_i;
                else if (io_addr_i == `EBA_ADDR_PTR_HIGH)
                    nv_byte_pointer_r[AW-1:8] <= io_wdata_i[AW-9:0];
            end

            if (wr_ctl) begin
                nv_ready_irq_enable_r <= io_wdata_i[`EBA_BIT_IRQ_EN];
                if (!nv_write_strobe_r)
                    nv_prog_mode_r <= io_wdata_i[`EBA_BIT_MODE_HI:`EBA_BIT_MODE_LO];
            end

            // Arm window: self-clears after four cycles
            if (wr_ctl && io_wdata_i[`EBA_BIT_ARM] && !io_wdata_i[`EBA_BIT_WRITE]) begin
                nv_write_arm_r <= 1'b1;
                arm_cnt_r      <= `EBA_ARM_CYCLES;
            end else if (start_write || arm_cnt_r <= 3'h1) begin
                nv_write_arm_r <= 1'b0;
                arm_cnt_r      <= 3'h0;
            end else begin
                arm_cnt_r <= arm_cnt_r - 3'h1;
            end

            if (start_read) begin
                nv_read_strobe_r <= 1'b1;
                nv_byte_value_r  <= mem_r[nv_byte_pointer_r];
            end

            if (start_write) begin
                nv_write_strobe_r <= 1'b1;
                op_mode_r <= io_wdata_i[`EBA_BIT_MODE_HI:`EBA_BIT_MODE_LO];
                op_addr_r <= nv_byte_pointer_r;
                op_data_r <= nv_byte_value_r;
                prog_cnt_r <= (io_wdata_i[`EBA_BIT_MODE_HI:`EBA_BIT_MODE_LO] ==
                               `EBA_MODE_ATOMIC) ? T_ATOMIC_CY : T_SPLIT_CY;
            end else if (nv_write_strobe_r) begin
                if (prog_cnt_r > 32'h1) begin
                    prog_cnt_r <= prog_cnt_r - 32'h1;
                end else begin
                    if (op_mode_r != `EBA_MODE_RSVD)
                        mem_r[op_addr_r] <= prog_byte;
                    nv_write_strobe_r <= 1'b0;
                    prog_cnt_r        <= 32'h0;
                end
            end

            if (start_read) begin
                stall_cnt_r <= `EBA_READ_STALL;
                cpu_stall_o <= 1'b1;
            end else if (start_write) begin
                stall_cnt_r <= `EBA_WRITE_STALL;
                cpu_stall_o <= 1'b1;
            end else if (stall_cnt_r > 3'h1) begin
                stall_cnt_r <= stall_cnt_r - 3'h1;
            end else begin
                stall_cnt_r <= 3'h0;
                cpu_stall_o <= 1'b0;
            end
        end
    end

endmodule

// *** eba_port_bench.sv ***
`timescale 1ns/1ns
module eba_port_bench;
    reg        ref_clk_i;
    reg        rst_i;
    wire [5:0] io_addr_i;
    wire       io_wr_i, io_rd_i, cpu_stall_o, nv_ready_o, nv_ready_irq_o;
    wire [7:0] io_wdata_i;
    wire [7:0] io_rdata_o;
    integer    fails, n_checks, i, k;
    reg  [7:0] q, d0, d1;
    reg  [8:0] a;
    eba_port #(.T_ATOMIC_CY(20), .T_SPLIT_CY(10)) DUT (.ref_clk_i, .rst_i, .io_addr_i,
        .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .cpu_stall_o, .nv_ready_o, .nv_ready_irq_o);
    eba_cpu_model core (.ref_clk_i, .stall_i(cpu_stall_o), .rdata_i(io_rdata_o),
        .addr_o(io_addr_i), .wr_o(io_wr_i), .rd_o(io_rd_i), .wdata_o(io_wdata_i));
    function [7:0] exp_b(input [1:0] m, input [7:0] o, input [7:0] n);
        exp_b = m == 2'h0 ? n : m == 2'h1 ? 8'hFF : m == 2'h2 ? (o & n) : o;
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task wr(input [5:0] r, input [7:0] v); core.acc(r, v, 1'b1, q); endtask
    task rd(input [5:0] r); core.acc(r, 8'h00, 1'b0, q); endtask
    // Pointer loaded low byte first; bit 8 written from p[8] into the high pointer register
    task setp(input [8:0] p); begin wr(6'h21, p[7:0]); wr(6'h22, {7'h0, p[8]}); end endtask
    task wait_idle;
        begin
            rd(6'h1F);
            for (k = 0; k < 40 && q[1]; k = k + 1) rd(6'h1F);
            if (q[1]) begin chk(q, 8'h00); end_sim; end
        end
    endtask
    task nvw(input [8:0] p, input [7:0] d, input [1:0] m);
        begin
            setp(p); wr(6'h20, d); wr(6'h1F, 8'h04); wr(6'h1F, {2'h0, m, 4'h2});
            wait_idle;
            chk({7'h0, nv_ready_o}, 8'h01);
        end
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        fails = 0; n_checks = 0; rst_i = 1'b1; d0 = $urandom(32'h488A);
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        rd(6'h1F); chk(q, 8'h00);
        rd(6'h05); chk(q, 8'h00);
        wr(6'h22, 8'hFF); rd(6'h22); chk(q, 8'h01);
        $display("register test done");
        for (i = 0; i < 4; i = i + 1) begin
            a = $urandom; d0 = $urandom; d1 = $urandom;
            if (i == 0) a = 9'h000;
            if (i == 3) a = 9'h1FF;
            nvw(a, d0, 2'h0); nvw(a, d1, i[1:0]);
            setp(a); wr(6'h1F, 8'h01); rd(6'h20);
            chk(q, exp_b(i[1:0], d0, d1));
            $display("mode %0d test done", i);
        end
        setp(9'h0A5); wr(6'h20, 8'h3C); wr(6'h1F, 8'h04); wr(6'h1F, 8'h02);
        rd(6'h1F); chk(q, 8'h02);
        wr(6'h21, 8'h5A); wr(6'h1F, 8'h01); wait_idle;
        rd(6'h21); chk(q, 8'hA5); rd(6'h20); chk(q, 8'h3C);
        $display("busy test done");
        wr(6'h20, 8'h00); wr(6'h1F, 8'h02); rd(6'h1F); chk(q, 8'h00);
        wr(6'h1F, 8'h04); rd(6'h1F); chk(q, 8'h04);
        repeat (6) @(negedge ref_clk_i);
        wr(6'h1F, 8'h02); rd(6'h1F); chk(q, 8'h00);
        setp(9'h0A5); wr(6'h1F, 8'h01); rd(6'h20); chk(q, 8'h3C);
        $display("arm test done");
        wr(6'h1F, 8'h08); rd(6'h1F); chk({7'h0, nv_ready_irq_o}, 8'h01);
        wr(6'h1F, 8'h00); rd(6'h1F); chk({7'h0, nv_ready_irq_o}, 8'h00);
        $display("ready event test done");
        end_sim;
    end
endmodule

// *** eba_port_monitor.sv ***
`timescale 1ns/1ns
module eba_port_monitor (
    input wire       ref_clk_i,
    input wire       rst_i,
    input wire [5:0] io_addr_i,
    input wire       io_wr_i,
    input wire       io_rd_i,
    input wire [7:0] io_wdata_i,
    input wire [7:0] io_rdata_o,
    input wire       cpu_stall_o,
    input wire       nv_ready_o,
    input wire       nv_ready_irq_o
);
    reg  [2:0] arm_r;
    wire       cw = io_wr_i && io_addr_i == 6'h1F;
    wire       rm = io_rd_i && (io_addr_i < 6'h1F || io_addr_i > 6'h22);
    // Mirror of the arm window
    always @(posedge ref_clk_i)
        if (rst_i) arm_r <= 3'h0;
        else if (cw && io_wdata_i[2:1] == 2'h2) arm_r <= 3'h4;
        else if (arm_r != 3'h0) arm_r <= arm_r - 3'h1;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_go; cw && io_wdata_i[2:1] == 2'h1 && nv_ready_o; endsequence
    sequence s_hold; cpu_stall_o [*2] ##1 !cpu_stall_o && !nv_ready_o; endsequence
    property p_wr; s_go ##0 arm_r != 3'h0 |=> s_hold; endproperty
    a_wr: assert property (p_wr) else $error("write stall wrong");
    property p_stray; s_go ##0 arm_r == 3'h0 |=> !cpu_stall_o [*2]; endproperty
    a_stray: assert property (p_stray) else $error("unarmed write ran");
    property p_rd; cw && io_wdata_i[1:0] == 2'h1 && nv_ready_o
        |=> cpu_stall_o [*4] ##1 !cpu_stall_o; endproperty
    a_rd: assert property (p_rd) else $error("read stall wrong");
    property p_unmap; rm |-> ##2 io_rdata_o == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hi; io_rd_i && io_addr_i == 6'h22 |-> ##2 io_rdata_o[7:1] == 7'h00; endproperty
    a_hi: assert property (p_hi) else $error("pointer high bits");
    property p_irq; nv_ready_irq_o |-> nv_ready_o; endproperty
    a_irq: assert property (p_irq) else $error("ready event");
    property p_done; $fell(nv_ready_o) |-> ##[1:60] nv_ready_o; endproperty
    a_done: assert property (p_done) else $error("write never ends");
    property p_lng; cpu_stall_o [*4] |=> !cpu_stall_o; endproperty
    a_lng: assert property (p_lng) else $error("stall too long");
endmodule
bind eba_port eba_port_monitor u_mon (.ref_clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i,
    .io_wdata_i, .io_rdata_o, .cpu_stall_o, .nv_ready_o, .nv_ready_irq_o);
